// ==== rtl/ufi_pkg.sv ====
/*
 * Shared constants and carrier types for the unit format and identify command handler.
 * Assumes a single 125 MHz clock domain and a surrounding drive controller that owns the media.
 */
package ufi_pkg;

    // ==========================================================
    // Command codes and feature value
    // ==========================================================
    localparam logic [7:0] UFI_CMD_FORMAT = 8'hF7;
    localparam logic [7:0] UFI_CMD_IDENTIFY = 8'hEC;
    localparam logic [7:0] UFI_CMD_ERASE_PREP = 8'hF3;
    localparam logic [7:0] UFI_FEAT_FORMAT = 8'h11;

    // ==========================================================
    // Status and error bit positions
    // ==========================================================
    localparam int UFI_ST_BSY = 7;
    localparam int UFI_ST_RDY = 6;
    localparam int UFI_ST_DSC = 4;
    localparam int UFI_ST_DRQ = 3;
    localparam int UFI_ST_ERR = 0;
    localparam int UFI_ER_ABT = 2;
    localparam logic [7:0] UFI_STATUS_RST = 8'h50;
    localparam logic [7:0] UFI_ERROR_RST = 8'h00;
    localparam logic [7:0] UFI_DHS_RST = 8'hA0;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int UFI_LBA_W = 48;
    localparam int UFI_SECTOR_WORDS = 256;
    localparam int UFI_WIDX_W = 8;
    localparam int UFI_DEFECT_DEPTH = 16;
    localparam int UFI_DIDX_W = 4;
    localparam logic [UFI_LBA_W-1:0] UFI_LBA_ZERO = 48'h0000_0000_0000;
    localparam logic [UFI_LBA_W-1:0] UFI_LBA_ONE = 48'h0000_0000_0001;

    // ==========================================================
    // Carriers
    // ==========================================================
    // Host write to the command block
    typedef struct packed {
        logic feature_we;
        logic dhs_we;
        logic cmd_we;
        logic [7:0] wdata;
    } ufi_host_wr_t;

    // Media write request to the drive back end
    typedef struct packed {
        logic valid;
        logic [UFI_LBA_W-1:0] lba;
    } ufi_media_req_t;

    typedef enum logic [2:0] {
        UFI_IDLE = 3'b000,
        UFI_MERGE = 3'b001,
        UFI_WIPE = 3'b010,
        UFI_WAIT = 3'b011,
        UFI_SEND = 3'b100,
        UFI_DONE = 3'b101
    } ufi_state_t;

endpackage : ufi_pkg

// ==== rtl/ufi_defect_store.sv ====
/*
 * Defect and reassignment list store with a merge operation.
 * Assumes the controller holds off new reassignments while a merge runs.
 */
`timescale 1ns/1ps
module ufi_defect_store (
    input wire logic clk,
    input wire logic resetn,
    input wire logic realloc_we,
    input wire logic [ufi_pkg::UFI_LBA_W-1:0] realloc_lba,
    input wire logic clear_all,
    input wire logic merge_step,
    input wire logic [ufi_pkg::UFI_DIDX_W-1:0] merge_idx,
    output logic [ufi_pkg::UFI_DIDX_W:0] realloc_count,
    output logic [ufi_pkg::UFI_DIDX_W:0] defect_count
);
    logic [ufi_pkg::UFI_LBA_W-1:0] realloc_mem [ufi_pkg::UFI_DEFECT_DEPTH];
    logic [ufi_pkg::UFI_LBA_W-1:0] defect_mem [ufi_pkg::UFI_DEFECT_DEPTH];
    logic [ufi_pkg::UFI_DIDX_W:0] rcnt_r;
    logic [ufi_pkg::UFI_DIDX_W:0] dcnt_r;
    logic merge_last;

    // Last merge step is the one that copies the newest reassignment
    assign merge_last = {1'b0, merge_idx} == rcnt_r - 1'b1;

    // ==========================================================
    // Reassignment list, cleared after merge
    // ==========================================================
    // Kept until folded in; clearing on the format strobe would merge nothing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rcnt_r <= '0;
        end else if (merge_step && merge_last) begin
            rcnt_r <= '0;
        end else if (realloc_we && rcnt_r < ufi_pkg::UFI_DEFECT_DEPTH) begin
            realloc_mem[rcnt_r[ufi_pkg::UFI_DIDX_W-1:0]] <= realloc_lba;
            rcnt_r <= rcnt_r + 1'b1;
        end
    end

    // ==========================================================
    // Defect list, rebuilt from the reassignments
    // ==========================================================
    // Clear drops old entries; merge then appends each reassignment in order
    always_ff @(posedge clk) begin
        if (!resetn || clear_all) begin
            dcnt_r <= '0;
        end else if (merge_step && dcnt_r < ufi_pkg::UFI_DEFECT_DEPTH) begin
            defect_mem[dcnt_r[ufi_pkg::UFI_DIDX_W-1:0]] <= realloc_mem[merge_idx];
            dcnt_r <= dcnt_r + 1'b1;
        end
    end

    assign realloc_count = rcnt_r;
    assign defect_count = dcnt_r;
endmodule : ufi_defect_store

// ==== rtl/ufi_cmd_core.sv ====
/*
 * Command handler for whole-unit format and identify on the command block registers.
 * Assumes host writes arrive as one-cycle strobes and the media back end acknowledges writes.
 */
// How it works
// - Command F7h with feature 11h is decoded as the whole-unit format.
// - Formatting folds reassigned sectors into the defect list, clears reassignments, then writes every sector.
// - The new lists are usable as soon as the format completes.
// - All earlier defect list contents are discarded by the format; reassignments are kept by merging them into the new defect list.
// - The format runs from block 0 through the native maximum block, ignoring reduced capacity.
// - Hidden protected regions are initialised too.
// - A format without a preceding erase-prepare F3h is aborted with an abort error.
// - The format has no data transfer phase.
// - Command ECh sends exactly one sector of configuration data.
`timescale 1ns/1ps
module ufi_cmd_core (
    input wire logic clk,
    input wire logic resetn,
    input wire ufi_pkg::ufi_host_wr_t host_wr,
    input wire logic [ufi_pkg::UFI_LBA_W-1:0] native_max_lba,
    input wire logic realloc_we,
    input wire logic [ufi_pkg::UFI_LBA_W-1:0] realloc_lba,
    input wire logic media_ack,
    input wire logic [15:0] ident_word,
    input wire logic data_rd,
    output logic [7:0] status_flags,
    output logic [7:0] error_flags,
    output logic [7:0] drive_head_select,
    output ufi_pkg::ufi_media_req_t media_req,
    output logic [ufi_pkg::UFI_WIDX_W-1:0] ident_addr,
    output logic [15:0] data_out,
    output logic lists_valid
);
    ufi_pkg::ufi_state_t state_r;
    logic [7:0] feature_r;
    logic [7:0] status_r;
    logic [7:0] error_r;
    logic [7:0] dhs_r;
    logic prep_armed_r;
    logic [ufi_pkg::UFI_LBA_W-1:0] lba_r;
    logic [ufi_pkg::UFI_LBA_W-1:0] max_r;
    logic [ufi_pkg::UFI_DIDX_W:0] merge_r;
    logic [ufi_pkg::UFI_WIDX_W:0] word_r;
    logic req_r;
    logic [15:0] dout_r;
    logic lists_valid_r;
    logic clear_all;
    logic merge_step;
    logic [ufi_pkg::UFI_DIDX_W:0] rcount;
    logic [ufi_pkg::UFI_DIDX_W:0] dcount;
    logic fmt_go;
    logic fmt_abort;
    logic id_go;
    logic other_cmd;

    // ==========================================================
    // Command decode
    // ==========================================================
    // Commands are ignored while busy, as on a real command block
    assign fmt_go = host_wr.cmd_we && state_r == ufi_pkg::UFI_IDLE && host_wr.wdata == ufi_pkg::UFI_CMD_FORMAT
                    && feature_r == ufi_pkg::UFI_FEAT_FORMAT && prep_armed_r;
    assign fmt_abort = host_wr.cmd_we && state_r == ufi_pkg::UFI_IDLE && host_wr.wdata == ufi_pkg::UFI_CMD_FORMAT
                       && !(feature_r == ufi_pkg::UFI_FEAT_FORMAT && prep_armed_r);
    assign id_go = host_wr.cmd_we && state_r == ufi_pkg::UFI_IDLE
                   && host_wr.wdata == ufi_pkg::UFI_CMD_IDENTIFY;
    assign other_cmd = host_wr.cmd_we && state_r == ufi_pkg::UFI_IDLE && !fmt_go && !fmt_abort && !id_go;
    assign clear_all = fmt_go;
    assign merge_step = state_r == ufi_pkg::UFI_MERGE && merge_r < rcount;

    // ==========================================================
    // Plain registers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            feature_r <= 8'h00;
            dhs_r <= ufi_pkg::UFI_DHS_RST;
        end else begin
            if (host_wr.feature_we) begin
                feature_r <= host_wr.wdata;
            end
            if (host_wr.dhs_we) begin
                dhs_r <= host_wr.wdata;
            end
        end
    end

    // Erase-prepare arms only the very next command
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prep_armed_r <= 1'b0;
        end else if (host_wr.cmd_we && state_r == ufi_pkg::UFI_IDLE) begin
            prep_armed_r <= host_wr.wdata == ufi_pkg::UFI_CMD_ERASE_PREP;
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= ufi_pkg::UFI_IDLE;
            merge_r <= '0;
            lba_r <= ufi_pkg::UFI_LBA_ZERO;
            max_r <= ufi_pkg::UFI_LBA_ZERO;
            word_r <= '0;
        end else begin
            unique case (state_r)
                ufi_pkg::UFI_IDLE: begin
                    merge_r <= '0;
                    word_r <= '0;
                    lba_r <= ufi_pkg::UFI_LBA_ZERO;
                    if (fmt_go) begin
                        // Native maximum, not the reduced user limit
                        max_r <= native_max_lba;
                        state_r <= ufi_pkg::UFI_MERGE;
                    end else if (id_go) begin
                        state_r <= ufi_pkg::UFI_SEND;
                    end
                end
                ufi_pkg::UFI_MERGE: begin
                    // Merge finishes before any sector is written
                    if (merge_r < rcount) begin
                        merge_r <= merge_r + 1'b1;
                    end else begin
                        state_r <= ufi_pkg::UFI_WIPE;
                    end
                end
                ufi_pkg::UFI_WIPE: begin
                    state_r <= ufi_pkg::UFI_WAIT;
                end
                ufi_pkg::UFI_WAIT: begin
                    if (media_ack) begin
                        if (lba_r == max_r) begin
                            state_r <= ufi_pkg::UFI_DONE;
                        end else begin
                            lba_r <= lba_r + ufi_pkg::UFI_LBA_ONE;
                            state_r <= ufi_pkg::UFI_WIPE;
                        end
                    end
                end
                ufi_pkg::UFI_SEND: begin
                    if (data_rd) begin
                        word_r <= word_r + 1'b1;
                        if (word_r == ufi_pkg::UFI_SECTOR_WORDS - 1) begin
                            state_r <= ufi_pkg::UFI_DONE;
                        end
                    end
                end
                ufi_pkg::UFI_DONE: begin
                    state_r <= ufi_pkg::UFI_IDLE;
                end
                default: begin
                    state_r <= ufi_pkg::UFI_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Status and error
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_r <= ufi_pkg::UFI_STATUS_RST;
            error_r <= ufi_pkg::UFI_ERROR_RST;
        end else if (fmt_abort || other_cmd) begin
            status_r <= ufi_pkg::UFI_STATUS_RST | 8'h01;
            error_r <= 8'h04;
        end else if (fmt_go) begin
            status_r <= 8'h80;
            error_r <= 8'h00;
        end else if (id_go) begin
            status_r <= 8'h80;
            error_r <= 8'h00;
        end else if (state_r == ufi_pkg::UFI_SEND) begin
            status_r <= 8'h58; // Data ready for the host
        end else if (state_r == ufi_pkg::UFI_DONE) begin
            status_r <= ufi_pkg::UFI_STATUS_RST;
        end
    end

    // ==========================================================
    // Media request, identify data, list validity
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            req_r <= 1'b0;
            dout_r <= 16'h0000;
            lists_valid_r <= 1'b1;
        end else begin
            req_r <= state_r == ufi_pkg::UFI_WIPE;
            dout_r <= ident_word;
            if (fmt_go) begin
                lists_valid_r <= 1'b0;
            end else if (state_r == ufi_pkg::UFI_DONE) begin
                lists_valid_r <= 1'b1;
            end
        end
    end

    ufi_defect_store u_store (
        .clk(clk),
        .resetn(resetn),
        .realloc_we(realloc_we && state_r == ufi_pkg::UFI_IDLE),
        .realloc_lba(realloc_lba),
        .clear_all(clear_all),
        .merge_step(merge_step),
        .merge_idx(merge_r[ufi_pkg::UFI_DIDX_W-1:0]),
        .realloc_count(rcount),
        .defect_count(dcount)
    );

    assign status_flags = status_r;
    assign error_flags = error_r;
    assign drive_head_select = dhs_r;
    assign media_req = '{valid: req_r, lba: lba_r};
    assign ident_addr = word_r[ufi_pkg::UFI_WIDX_W-1:0];
    assign data_out = dout_r;
    assign lists_valid = lists_valid_r;
endmodule : ufi_cmd_core

// ==== test/ufi_media_model.sv ====
/*
 * Behavioural media back end and identify word table facing the command core.
 * Assumes one clock and that the core raises one write request at a time.
 */
`timescale 1ns/1ps
module ufi_media_model #(
    parameter int ACK_DLY = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire ufi_pkg::ufi_media_req_t media_req,
    input wire logic [7:0] ident_addr,
    output logic media_ack,
    output logic [15:0] ident_word,
    output logic [15:0] wr_count,
    output logic [47:0] first_lba,
    output logic [47:0] last_lba
);
    logic pend_r;
    logic [7:0] dly_r;

    // ==========================================================
    // Identify table
    // ==========================================================
    // Each word differs in both bytes, so a stale index shows
    assign ident_word = {~ident_addr, ident_addr};

    // Slow acknowledge, so the core must really wait for each block
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pend_r <= 1'b0;
            dly_r <= 8'h00;
            media_ack <= 1'b0;
            wr_count <= 16'h0000;
            first_lba <= 48'h0000_0000_0000;
            last_lba <= 48'h0000_0000_0000;
        end else begin
            media_ack <= 1'b0;
            if (media_req.valid) begin
                pend_r <= 1'b1;
                dly_r <= 8'(ACK_DLY);
                wr_count <= wr_count + 16'h0001;
                last_lba <= media_req.lba;
                if (wr_count == 16'h0000) begin
                    first_lba <= media_req.lba;
                end
            end else if (pend_r) begin
                if (dly_r == 8'h00) begin
                    media_ack <= 1'b1;
                    pend_r <= 1'b0;
                end else begin
                    dly_r <= dly_r - 8'h01;
                end
            end
        end
    end
endmodule : ufi_media_model

// ==== test/ufi_cmd_core_monitor.sv ====
/*
 * Concurrent checks on the command core ports.
 * Assumes it is bound into ufi_cmd_core and sees only its ports.
 */
`timescale 1ns/1ps
module ufi_cmd_core_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire ufi_pkg::ufi_host_wr_t host_wr,
    input wire logic [47:0] native_max_lba,
    input wire logic data_rd,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] error_flags,
    input wire ufi_pkg::ufi_media_req_t media_req,
    input wire logic [7:0] ident_addr,
    input wire logic lists_valid
);
    logic [7:0] feat_r;
    wire logic bsy = status_flags[ufi_pkg::UFI_ST_BSY];
    wire logic drq = status_flags[ufi_pkg::UFI_ST_DRQ];
    wire logic err = status_flags[ufi_pkg::UFI_ST_ERR];
    wire logic rdy = status_flags[ufi_pkg::UFI_ST_RDY];
    wire logic idle = !bsy && !drq && host_wr.cmd_we;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Shadow of the feature value, so a format can be predicted
    always_ff @(posedge clk) begin
        if (!resetn) begin
            feat_r <= 8'h00;
        end else if (host_wr.feature_we) begin
            feat_r <= host_wr.wdata;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    a_fmt_no_data: assert property (media_req.valid |-> bsy && !drq)
        else $error("media write outside a busy, dataless format");
    a_abort_pair: assert property (err |-> error_flags[ufi_pkg::UFI_ER_ABT] && rdy)
        else $error("error status without abort bit");
    a_busy_flags: assert property (bsy |-> !rdy && !err)
        else $error("ready or error shown while busy");
    a_lists_busy: assert property (!lists_valid |-> bsy)
        else $error("lists unusable after completion");
    a_lba_range: assert property (media_req.valid |-> media_req.lba <= native_max_lba)
        else $error("block beyond native maximum");
    a_ident_start: assert property (idle && host_wr.wdata == ufi_pkg::UFI_CMD_IDENTIFY
        |=> status_flags == 8'h80 ##1 status_flags == 8'h58) else $error("identify start wrong");
    a_addr_step: assert property (data_rd && drq && ident_addr != 8'hFF
        |=> ident_addr == $past(ident_addr) + 8'h01) else $error("word index did not advance");
    a_feat_abort: assert property (idle && host_wr.wdata == ufi_pkg::UFI_CMD_FORMAT && feat_r != 8'h11
        |=> status_flags == 8'h51 && error_flags == 8'h04) else $error("bad feature not aborted");
endmodule : ufi_cmd_core_monitor

bind ufi_cmd_core ufi_cmd_core_monitor i_ufi_cmd_core_monitor (.clk(clk), .resetn(resetn), .host_wr(host_wr),
    .native_max_lba(native_max_lba), .data_rd(data_rd), .status_flags(status_flags), .error_flags(error_flags),
    .media_req(media_req), .ident_addr(ident_addr), .lists_valid(lists_valid));

// ==== test/testbench.sv ====
/*
 * Self-checking bench for the command core, acting as host adapter.
 * Assumes the media model answers writes and serves identify words.
 */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    ufi_pkg::ufi_host_wr_t hw = '0;
    logic realloc_we = 1'b0;
    logic [47:0] realloc_lba = 48'h0000_0000_0000;
    logic data_rd = 1'b0;
    logic media_ack, lists_valid;
    logic [15:0] ident_word, data_out, wr_count;
    logic [7:0] status_flags, error_flags, drive_head_select, ident_addr;
    logic [47:0] first_lba, last_lba;
    ufi_pkg::ufi_media_req_t media_req;
    int num_errors = 0;
    int n_compared = 0;
    localparam logic [47:0] MAX_LBA = 48'h0000_0000_0005;

    ufi_cmd_core i_ufi_cmd_core (.clk(clk), .resetn(resetn), .host_wr(hw), .native_max_lba(MAX_LBA),
        .realloc_we(realloc_we), .realloc_lba(realloc_lba), .media_ack(media_ack), .ident_word(ident_word),
        .data_rd(data_rd), .status_flags(status_flags), .error_flags(error_flags),
        .drive_head_select(drive_head_select), .media_req(media_req), .ident_addr(ident_addr),
        .data_out(data_out), .lists_valid(lists_valid));
    ufi_media_model i_ufi_media_model (.clk(clk), .resetn(resetn), .media_req(media_req), .ident_addr(ident_addr),
        .media_ack(media_ack), .ident_word(ident_word), .wr_count(wr_count), .first_lba(first_lba),
        .last_lba(last_lba));

    // ==========================================================
    // Clock, watchdog and shared tasks
    // ==========================================================
    // 125 MHz
    initial begin
        forever #4 clk = ~clk;
    end

    // Whole run is a few hundred cycles; this is generous
    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // One strobe cycle; k picks feature, device/head or command
    task automatic hwrite(input int k, input logic [7:0] d);
        @(posedge clk);
        #1;
        hw.feature_we = (k == 0);
        hw.dhs_we = (k == 1);
        hw.cmd_we = (k == 2);
        hw.wdata = d;
        @(posedge clk);
        #1;
        hw = '0;
    endtask : hwrite

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_refusals();
        chk(status_flags, 8'h50);
        chk(drive_head_select, 8'hA0);
        hwrite(1, 8'hE0);
        chk(drive_head_select, 8'hE0);
        hwrite(0, 8'h11);
        hwrite(2, 8'hF7);
        chk({status_flags, error_flags}, 16'h5104);
        hwrite(2, 8'hF3);
        hwrite(0, 8'h22);
        hwrite(2, 8'hF7);
        chk({status_flags, error_flags}, 16'h5104);
    endtask : t_refusals

    task automatic t_format();
        int n;
        for (n = 0; n < 2; n++) begin
            @(posedge clk);
            #1;
            realloc_we = 1'b1;
            realloc_lba = 48'(n + 3);
            @(posedge clk);
            #1;
            realloc_we = 1'b0;
        end
        hwrite(0, 8'h11);
        hwrite(2, 8'hF3);
        hwrite(2, 8'hF7);
        chk({status_flags, 7'h00, lists_valid}, 16'h8000);
        // Two merge steps and the merge exit come before the first block write
        n = 0;
        while (!media_req.valid && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, 4);
        hwrite(2, 8'hEC);
        n = 0;
        // Bounded wait, as a host would size it from the capacity
        while (status_flags !== 8'h50 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n < 3000, 1);
        chk(wr_count, 16'h0006);
        chk(first_lba, 48'h0000_0000_0000);
        chk(last_lba, MAX_LBA);
        chk({lists_valid, error_flags}, 9'h100);
    endtask : t_format

    task automatic t_identify();
        logic [7:0] w;
        hwrite(2, 8'hEC);
        chk(status_flags, 8'h80);
        for (int i = 0; i < 256; i++) begin
            w = 8'(i);
            @(posedge clk);
            #1;
            chk(status_flags, 8'h58);
            chk(data_out, {~w, w});
            data_rd = 1'b1;
            @(posedge clk);
            #1;
            data_rd = 1'b0;
        end
        repeat (2) @(posedge clk);
        #1;
        chk(status_flags, 8'h50);
    endtask : t_identify

    // Reset held for six cycles, then the scenarios in order
    initial begin
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_refusals();
        t_format();
        t_identify();
        close_out();
    end
endmodule : testbench
